// ### src/pme_link_if.sv
// Register access link between the programming host and the sensor.
`timescale 1ns/1ps
interface pme_link_if;
    import pme_pkg::*;

    logic req_valid;
    logic req_write;
    logic [ADDR_W-1:0] req_addr;
    logic [DATA_W-1:0] req_wdata;
    logic rsp_valid;
    logic [DATA_W-1:0] rsp_rdata;

    modport device (
        input req_valid,
        input req_write,
        input req_addr,
        input req_wdata,
        output rsp_valid,
        output rsp_rdata
    );

    modport host (
        output req_valid,
        output req_write,
        output req_addr,
        output req_wdata,
        input rsp_valid,
        input rsp_rdata
    );

endinterface : pme_link_if

// ### src/pme_pkg.sv
// Shared constants and types for the programming mode entry link.
package pme_pkg;

    // ------------------------------------------------------------------
    // Clock and listening window timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int US_PER_MS = 1000;
    localparam int LISTEN_TIME_MS = 110;
    localparam int LISTEN_CYCLES = LISTEN_TIME_MS * US_PER_MS * CLK_MHZ;

    // ------------------------------------------------------------------
    // Link widths and device register map
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int CFG_DEPTH_DEF = 32;
    localparam logic [ADDR_W-1:0] ADDR_CFG_BASE = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_MEAS = 8'h70;
    localparam logic [ADDR_W-1:0] ADDR_MODE_KEY = 8'h75;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h7E;
    localparam logic [ADDR_W-1:0] ADDR_LOCK = 8'h7F;
    localparam logic [DATA_W-1:0] KEY_LISTEN = 16'h22A2;
    localparam logic [DATA_W-1:0] KEY_PROG = 16'h2EAE;
    localparam logic [DATA_W-1:0] CFG_RESET = 16'h0000;
    localparam int LOCK_BIT = 0;
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_LOCK_BIT = 2;

    // ------------------------------------------------------------------
    // Host software register map
    // ------------------------------------------------------------------
    localparam int SW_ADDR_W = 3;
    localparam logic [SW_ADDR_W-1:0] HREG_ADDR = 3'h0;
    localparam logic [SW_ADDR_W-1:0] HREG_WDATA = 3'h1;
    localparam logic [SW_ADDR_W-1:0] HREG_CMD = 3'h2;
    localparam logic [SW_ADDR_W-1:0] HREG_STATUS = 3'h3;
    localparam logic [SW_ADDR_W-1:0] HREG_RDATA = 3'h4;
    localparam int CMD_WRITE_BIT = 0;
    localparam int CMD_READ_BIT = 1;
    localparam int CMD_ENTER_BIT = 2;
    localparam int CMD_LOCK_BIT = 3;
    localparam int HSTAT_BUSY_BIT = 0;
    localparam int HSTAT_LOCK_OK_BIT = 1;

    typedef enum logic [1:0] {
        MODE_APP,
        MODE_LISTEN,
        MODE_PROG
    } mode_e;

endpackage : pme_pkg

// ### src/program_host.sv
// Host end: runs software commands as register accesses on the link.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
module program_host
    import pme_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_nrst,
    pme_link_if.host link,
    input wire logic [SW_ADDR_W-1:0] i_sw_addr,
    input wire logic [DATA_W-1:0] i_sw_wdata,
    input wire logic i_sw_we,
    input wire logic i_sw_re,
    output logic [DATA_W-1:0] o_sw_rdata
);

    typedef enum logic [1:0] {
        H_IDLE,
        H_SEND,
        H_WAIT
    } hstate_e;

    typedef enum logic [1:0] {
        OP_WRITE,
        OP_READ,
        OP_ENTER,
        OP_LOCK
    } op_e;

    typedef struct packed {
        hstate_e state;
        op_e op;
        logic step;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] rdata;
        logic lock_ok;
        logic req_valid;
        logic req_write;
        logic [ADDR_W-1:0] req_addr;
        logic [DATA_W-1:0] req_wdata;
        logic [DATA_W-1:0] sw_rdata;
    } host_s;

    host_s st_reg;
    host_s st_next;

    // ------------------------------------------------------------------
    // Software port and sequencer
    // ------------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.req_valid = 1'b0;
        st_next.sw_rdata = '0;

        if (i_sw_re) begin
            case (i_sw_addr)
                HREG_ADDR: st_next.sw_rdata = DATA_W'(st_reg.addr);
                HREG_WDATA: st_next.sw_rdata = st_reg.wdata;
                HREG_STATUS: begin
                    st_next.sw_rdata[HSTAT_BUSY_BIT] =
                        (st_reg.state != H_IDLE);
                    st_next.sw_rdata[HSTAT_LOCK_OK_BIT] = st_reg.lock_ok;
                end
                HREG_RDATA: st_next.sw_rdata = st_reg.rdata;
                default: st_next.sw_rdata = '0;
            endcase
        end

        if (i_sw_we && (st_reg.state == H_IDLE)) begin
            case (i_sw_addr)
                HREG_ADDR: st_next.addr = i_sw_wdata[ADDR_W-1:0];
                HREG_WDATA: st_next.wdata = i_sw_wdata;
                HREG_CMD: begin
                    st_next.step = 1'b0;
                    if (i_sw_wdata[CMD_WRITE_BIT]) begin
                        st_next.op = OP_WRITE;
                        st_next.state = H_SEND;
                    end else if (i_sw_wdata[CMD_READ_BIT]) begin
                        st_next.op = OP_READ;
                        st_next.state = H_SEND;
                    end else if (i_sw_wdata[CMD_ENTER_BIT]) begin
                        st_next.op = OP_ENTER;
                        st_next.state = H_SEND;
                    end else if (i_sw_wdata[CMD_LOCK_BIT]) begin
                        st_next.op = OP_LOCK;
                        st_next.lock_ok = 1'b0;
                        st_next.state = H_SEND;
                    end
                end
                default: begin
                end
            endcase
        end

        case (st_reg.state)
            H_SEND: begin
                st_next.req_valid = 1'b1;
                st_next.state = H_WAIT;
                case (st_reg.op)
                    OP_WRITE: begin
                        st_next.req_write = 1'b1;
                        st_next.req_addr = st_reg.addr;
                        st_next.req_wdata = st_reg.wdata;
                    end
                    OP_READ: begin
                        st_next.req_write = 1'b0;
                        st_next.req_addr = st_reg.addr;
                        st_next.req_wdata = '0;
                    end
                    OP_ENTER: begin
                        st_next.req_write = 1'b1;
                        st_next.req_addr = ADDR_MODE_KEY;
                        st_next.req_wdata = st_reg.step ? KEY_PROG
                                                        : KEY_LISTEN;
                    end
                    default: begin
                        st_next.req_write = !st_reg.step;
                        st_next.req_addr = ADDR_LOCK;
                        st_next.req_wdata = '0;
                        st_next.req_wdata[LOCK_BIT] = !st_reg.step;
                    end
                endcase
            end
            H_WAIT: begin
                if (link.rsp_valid) begin
                    if (!st_reg.req_write) begin
                        st_next.rdata = link.rsp_rdata;
                    end
                    if ((st_reg.op == OP_LOCK) && st_reg.step) begin
                        st_next.lock_ok = link.rsp_rdata[LOCK_BIT];
                    end
                    if (((st_reg.op == OP_ENTER) || (st_reg.op == OP_LOCK))
                        && !st_reg.step) begin
                        st_next.step = 1'b1;
                        st_next.state = H_SEND;
                    end else begin
                        st_next.state = H_IDLE;
                    end
                end
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign link.req_valid = st_reg.req_valid;
    assign link.req_write = st_reg.req_write;
    assign link.req_addr = st_reg.req_addr;
    assign link.req_wdata = st_reg.req_wdata;
    assign o_sw_rdata = st_reg.sw_rdata;

endmodule : program_host

// ### src/sensor_mode_ctrl.sv
// Sensor end: mode control, configuration memory and lock.
`timescale 1ns/1ps
module sensor_mode_ctrl
    import pme_pkg::*;
#(
    parameter int LISTEN_CYC = LISTEN_CYCLES,
    parameter int CFG_DEPTH = CFG_DEPTH_DEF
) (
    input wire logic i_mclk,
    input wire logic i_nrst,
    pme_link_if.device link,
    input wire logic [DATA_W-1:0] i_meas_data,
    input wire logic [$clog2(CFG_DEPTH)-1:0] i_cfg_idx,
    output mode_e o_mode,
    output logic o_locked,
    output logic o_reset_pulse,
    output logic [DATA_W-1:0] o_cfg_word
);

    localparam int IDX_W = $clog2(CFG_DEPTH);

    typedef struct packed {
        mode_e mode;
        logic locked;
        logic [CFG_DEPTH-1:0][DATA_W-1:0] mem;
        logic rsp_valid;
        logic [DATA_W-1:0] rsp_rdata;
        logic reset_pulse;
        logic [DATA_W-1:0] cfg_word;
    } dev_s;

    dev_s st_reg;
    dev_s st_next;
    logic win_expired;
    logic key_listen_ok;
    logic key_prog_ok;
    logic cfg_hit;
    logic [IDX_W-1:0] cfg_idx;

    // ------------------------------------------------------------------
    // Listening window timer
    // ------------------------------------------------------------------
    window_timer #(
        .COUNT(LISTEN_CYC)
    ) u_listen_timer (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .i_start(key_listen_ok),
        .i_cancel(key_prog_ok),
        .o_expired(win_expired)
    );

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    assign cfg_hit = (int'(link.req_addr) < CFG_DEPTH);
    assign cfg_idx = link.req_addr[IDX_W-1:0];

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.rsp_valid = 1'b0;
        st_next.rsp_rdata = '0;
        st_next.reset_pulse = 1'b0;
        st_next.cfg_word = st_reg.mem[i_cfg_idx];
        key_listen_ok = 1'b0;
        key_prog_ok = 1'b0;

        if ((st_reg.mode == MODE_LISTEN) && win_expired) begin
            st_next.mode = MODE_APP;
            st_next.reset_pulse = 1'b1;
        end

        if (link.req_valid) begin
            st_next.rsp_valid = 1'b1;
            if (link.req_write) begin
                if (link.req_addr == ADDR_MODE_KEY) begin
                    if ((st_reg.mode == MODE_APP) && !st_reg.locked &&
                        (link.req_wdata == KEY_LISTEN)) begin
                        key_listen_ok = 1'b1;
                        st_next.mode = MODE_LISTEN;
                    end else if ((st_reg.mode == MODE_LISTEN) &&
                                 !st_reg.locked &&
                                 (link.req_wdata == KEY_PROG)) begin
                        key_prog_ok = 1'b1;
                        st_next.mode = MODE_PROG;
                        st_next.reset_pulse = 1'b0;
                    end
                end else if (cfg_hit) begin
                    if ((st_reg.mode == MODE_PROG) && !st_reg.locked) begin
                        st_next.mem[cfg_idx] = link.req_wdata;
                    end
                end else if (link.req_addr == ADDR_LOCK) begin
                    if ((st_reg.mode == MODE_PROG) && !st_reg.locked &&
                        link.req_wdata[LOCK_BIT]) begin
                        st_next.locked = 1'b1;
                        st_next.mode = MODE_APP;
                    end
                end
            end else begin
                if (cfg_hit) begin
                    st_next.rsp_rdata = st_reg.mem[cfg_idx];
                end else begin
                    case (link.req_addr)
                        ADDR_MEAS: begin
                            st_next.rsp_rdata = i_meas_data;
                        end
                        ADDR_STATUS: begin
                            st_next.rsp_rdata[STAT_MODE_LSB +: 2] =
                                st_reg.mode;
                            st_next.rsp_rdata[STAT_LOCK_BIT] =
                                st_reg.locked;
                        end
                        ADDR_LOCK: begin
                            st_next.rsp_rdata[LOCK_BIT] =
                                st_reg.locked;
                        end
                        default: begin
                            st_next.rsp_rdata = '0;
                        end
                    endcase
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_reg.mode <= MODE_APP;
            st_reg.locked <= 1'b0;
            st_reg.mem <= {CFG_DEPTH{CFG_RESET}};
            st_reg.rsp_valid <= 1'b0;
            st_reg.rsp_rdata <= '0;
            st_reg.reset_pulse <= 1'b0;
            st_reg.cfg_word <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign link.rsp_valid = st_reg.rsp_valid;
    assign link.rsp_rdata = st_reg.rsp_rdata;
    assign o_mode = st_reg.mode;
    assign o_locked = st_reg.locked;
    assign o_reset_pulse = st_reg.reset_pulse;
    assign o_cfg_word = st_reg.cfg_word;

endmodule : sensor_mode_ctrl

// ### src/window_timer.sv
// One-shot down counter that flags the end of a fixed window.
`timescale 1ns/1ps
module window_timer #(
    parameter int COUNT = 16
) (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_start,
    input wire logic i_cancel,
    output logic o_expired
);

    localparam int CNT_W = $clog2(COUNT + 1);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic running;
    } tmr_s;

    tmr_s st_reg;
    tmr_s st_next;

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    assign o_expired = st_reg.running && (st_reg.cnt == '0);

    always_comb begin
        st_next = st_reg;
        if (i_start) begin
            st_next.cnt = CNT_W'(COUNT - 1);
            st_next.running = 1'b1;
        end else if (i_cancel || o_expired) begin
            st_next.running = 1'b0;
        end else if (st_reg.running) begin
            st_next.cnt = st_reg.cnt - 1'b1;
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule : window_timer

// ### testbench/pme_link_properties.sv
// Checker for the programming mode entry link.
`timescale 1ns/1ps
module pme_link_properties
    import pme_pkg::*;
#(
    parameter int LISTEN_CYC = 20
) (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    input wire logic rsp_valid,
    input wire logic [DATA_W-1:0] rsp_rdata,
    input mode_e o_mode,
    input wire logic o_locked,
    input wire logic o_reset_pulse
);
    // ------------------------------------------------------------------
    // Helper logic and properties
    // ------------------------------------------------------------------
    int listen_cnt_reg;
    logic key_wr;
    assign key_wr = req_valid && req_write && req_addr == ADDR_MODE_KEY;

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            listen_cnt_reg <= 0;
        end else if (o_mode == MODE_LISTEN) begin
            listen_cnt_reg <= listen_cnt_reg + 1;
        end else begin
            listen_cnt_reg <= 0;
        end
    end

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_nrst);

    chk_rsp_follows: assert property (req_valid |=> rsp_valid)
        else $error("no answer after request");
    chk_rsp_caused: assert property (rsp_valid |-> $past(req_valid))
        else $error("answer without request");
    chk_write_zero: assert property (
        req_valid && req_write |=> rsp_rdata == 16'h0000)
        else $error("write answer carries data");
    chk_listen_entry: assert property (
        key_wr && req_wdata == KEY_LISTEN && o_mode == MODE_APP && !o_locked
        |=> o_mode == MODE_LISTEN)
        else $error("first key did not open window");
    chk_prog_entry: assert property (
        key_wr && req_wdata == KEY_PROG && o_mode == MODE_LISTEN
        |=> o_mode == MODE_PROG)
        else $error("second key did not enter programming");
    chk_listen_bound: assert property (
        o_mode == MODE_LISTEN |-> listen_cnt_reg < LISTEN_CYC)
        else $error("listening window too long");
    chk_expiry_return: assert property (
        o_mode == MODE_LISTEN && listen_cnt_reg == LISTEN_CYC - 1
        && !(key_wr && req_wdata == KEY_PROG)
        |=> o_mode == MODE_APP && o_reset_pulse)
        else $error("window expiry did not reset");
    chk_pulse_cause: assert property (
        o_reset_pulse |-> o_mode == MODE_APP && $past(o_mode) == MODE_LISTEN)
        else $error("reset pulse without expiry");
    chk_lock_app: assert property (o_locked |-> o_mode == MODE_APP)
        else $error("locked device left application mode");
    chk_lock_sticky: assert property ($past(o_locked) |-> o_locked)
        else $error("lock bit cleared");
    chk_lock_read: assert property (
        req_valid && !req_write && req_addr == ADDR_LOCK
        |=> rsp_rdata[LOCK_BIT] == o_locked)
        else $error("lock bit read back wrong");

    cov_listen: cover property (o_mode == MODE_LISTEN);
    cov_prog: cover property (o_mode == MODE_PROG);
    cov_expiry: cover property (o_reset_pulse);
    cov_lock: cover property ($rose(o_locked));
endmodule : pme_link_properties

// ### testbench/testbench.sv
// Self-checking bench for the programming mode entry link.
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) begin \
            fails++; \
            $display("MISMATCH %s exp %0h got %0h", nm, exp, got); \
        end \
    end
module testbench;
    import pme_pkg::*;
    localparam int LCYC = 20;
    logic mclk;
    logic nrst;
    logic [SW_ADDR_W-1:0] sw_addr;
    logic [DATA_W-1:0] sw_wdata;
    logic sw_we;
    logic sw_re;
    logic [DATA_W-1:0] sw_rdata;
    logic [DATA_W-1:0] meas;
    logic [4:0] cfg_idx;
    mode_e mode;
    logic locked;
    logic rst_pulse;
    logic [DATA_W-1:0] cfg_word;
    logic [DATA_W-1:0] rd;
    int fails;
    int tests_run;
    int pulses;
    int m_mode;
    int m_lock;
    int m_mem[32];
    int a;

    pme_link_if u_pme_link_if ();
    sensor_mode_ctrl #(.LISTEN_CYC(LCYC), .CFG_DEPTH(32)) u_sensor_mode_ctrl (
        .i_mclk(mclk), .i_nrst(nrst), .link(u_pme_link_if.device),
        .i_meas_data(meas), .i_cfg_idx(cfg_idx), .o_mode(mode),
        .o_locked(locked), .o_reset_pulse(rst_pulse), .o_cfg_word(cfg_word));
    program_host u_program_host (
        .i_mclk(mclk), .i_nrst(nrst), .link(u_pme_link_if.host),
        .i_sw_addr(sw_addr), .i_sw_wdata(sw_wdata), .i_sw_we(sw_we),
        .i_sw_re(sw_re), .o_sw_rdata(sw_rdata));
    pme_link_properties #(.LISTEN_CYC(LCYC)) u_pme_link_properties (
        .i_mclk(mclk), .i_nrst(nrst),
        .req_valid(u_pme_link_if.req_valid),
        .req_write(u_pme_link_if.req_write),
        .req_addr(u_pme_link_if.req_addr),
        .req_wdata(u_pme_link_if.req_wdata),
        .rsp_valid(u_pme_link_if.rsp_valid),
        .rsp_rdata(u_pme_link_if.rsp_rdata),
        .o_mode(mode), .o_locked(locked), .o_reset_pulse(rst_pulse));

    // ------------------------------------------------------------------
    // Clock, model and bus tasks
    // ------------------------------------------------------------------
    always #5 mclk = ~mclk;

    always @(posedge mclk) begin
        if (rst_pulse === 1'b1) begin
            pulses++;
        end
    end

    function automatic void m_write(input int ad, input int d);
        if (ad == ADDR_MODE_KEY && m_lock == 0) begin
            if (d == KEY_LISTEN && m_mode == 0) begin
                m_mode = 1;
            end else if (d == KEY_PROG && m_mode == 1) begin
                m_mode = 2;
            end
        end
        if (ad < 32 && m_mode == 2 && m_lock == 0) begin
            m_mem[ad] = d;
        end
    endfunction : m_write

    function automatic int m_read(input int ad);
        if (ad < 32) begin
            return m_mem[ad];
        end
        if (ad == ADDR_MEAS) begin
            return meas;
        end
        if (ad == ADDR_STATUS) begin
            return (m_lock << STAT_LOCK_BIT) + m_mode;
        end
        if (ad == ADDR_LOCK) begin
            return m_lock;
        end
        return 0;
    endfunction : m_read

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic sw_wr(input logic [SW_ADDR_W-1:0] ra, input int d);
        @(posedge mclk);
        sw_addr <= ra;
        sw_wdata <= DATA_W'(d);
        sw_we <= 1'b1;
        @(posedge mclk);
        sw_we <= 1'b0;
    endtask : sw_wr

    task automatic sw_rd(input logic [SW_ADDR_W-1:0] ra);
        @(posedge mclk);
        sw_addr <= ra;
        sw_re <= 1'b1;
        @(posedge mclk);
        sw_re <= 1'b0;
        #1;
        rd = sw_rdata;
    endtask : sw_rd

    task automatic run_cmd(input int b);
        int n;
        sw_wr(HREG_CMD, 1 << b);
        n = 0;
        do begin
            sw_rd(HREG_STATUS);
            n++;
        end while (rd[HSTAT_BUSY_BIT] !== 1'b0 && n < 20);
        if (rd[HSTAT_BUSY_BIT] !== 1'b0) begin
            fails++;
            report_and_stop();
        end
    endtask : run_cmd

    task automatic link_wr(input int ad, input int d);
        d = d & 32'h0000_FFFF;
        sw_wr(HREG_ADDR, ad);
        sw_wr(HREG_WDATA, d);
        run_cmd(CMD_WRITE_BIT);
        m_write(ad, d);
    endtask : link_wr

    task automatic link_rd(input int ad);
        sw_wr(HREG_ADDR, ad);
        run_cmd(CMD_READ_BIT);
        sw_rd(HREG_RDATA);
    endtask : link_rd

    task automatic do_reset();
        nrst <= 1'b0;
        repeat (5) @(posedge mclk);
        nrst <= 1'b1;
        m_mode = 0;
        m_lock = 0;
        m_mem = '{default: 0};
    endtask : do_reset

    initial begin
        mclk = 1'b0;
        nrst = 1'b0;
        sw_addr = 3'h0;
        sw_wdata = 16'h0000;
        sw_we = 1'b0;
        sw_re = 1'b0;
        cfg_idx = 5'h00;
        fails = 0;
        tests_run = 0;
        pulses = 0;
        void'($urandom(32'h2829_2052));
        meas = DATA_W'($urandom);
        do_reset();
        `CHK("mode", MODE_APP, mode)
        link_wr(3, $urandom);
        link_rd(3);
        `CHK("cfg app", m_read(3), rd)
        link_rd(ADDR_STATUS);
        `CHK("status", m_read(ADDR_STATUS), rd)
        $display("test power_up done");

        link_wr(ADDR_MODE_KEY, KEY_LISTEN);
        `CHK("listen", MODE_LISTEN, mode)
        repeat (LCYC + 2) @(posedge mclk);
        #1;
        m_mode = 0;
        `CHK("expired", MODE_APP, mode)
        `CHK("pulses", 1, pulses)
        link_wr(ADDR_MODE_KEY, KEY_PROG);
        `CHK("late key", MODE_APP, mode)
        $display("test expiry done");

        link_wr(ADDR_MODE_KEY, KEY_LISTEN);
        link_wr(ADDR_MODE_KEY, KEY_PROG);
        `CHK("prog", MODE_PROG, mode)
        for (int i = 0; i < 6; i++) begin
            a = $urandom_range(31);
            link_wr(a, $urandom);
            link_rd(a);
            `CHK("cfg rw", m_read(a), rd)
        end
        cfg_idx <= 5'(a);
        repeat (3) @(posedge mclk);
        `CHK("cfg word", m_read(a), cfg_word)
        link_rd(ADDR_MEAS);
        `CHK("meas", m_read(ADDR_MEAS), rd)
        link_rd(8'h40);
        `CHK("unmapped", 0, rd)
        $display("test program done");

        for (int i = 0; i < 32; i++) begin
            link_rd(i);
            `CHK("readback", m_read(i), rd)
        end
        run_cmd(CMD_LOCK_BIT);
        m_lock = 1;
        m_mode = 0;
        sw_rd(HREG_STATUS);
        `CHK("lock ok", 1'b1, rd[HSTAT_LOCK_OK_BIT])
        `CHK("locked", 1'b1, locked)
        link_rd(ADDR_LOCK);
        `CHK("lock rd", m_read(ADDR_LOCK), rd)
        link_wr(ADDR_MODE_KEY, KEY_LISTEN);
        `CHK("key refused", MODE_APP, mode)
        run_cmd(CMD_ENTER_BIT);
        `CHK("enter refused", MODE_APP, mode)
        link_wr(a, $urandom);
        for (int i = 0; i < 32; i++) begin
            link_rd(i);
            `CHK("locked rd", m_read(i), rd)
        end
        $display("test lock done");

        do_reset();
        `CHK("unlocked", 1'b0, locked)
        link_wr(ADDR_MODE_KEY, KEY_LISTEN);
        do_reset();
        repeat (LCYC + 2) @(posedge mclk);
        `CHK("rst mode", MODE_APP, mode)
        `CHK("no pulse", 1, pulses)
        $display("test second_reset done");
        report_and_stop();
    end
endmodule : testbench
